// [shared/ime_pkg.sv]
`default_nettype none

package ime_pkg;

    // ==========================================================
    // register map of the internal register port
    // ==========================================================
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h01;
    localparam logic [7:0] ADDR_MASK = 8'h02;
    localparam logic [7:0] ADDR_MODE_0_7 = 8'h03;
    localparam logic [7:0] ADDR_MODE_8_15 = 8'h04;
    localparam logic [7:0] ADDR_MODE_16_19 = 8'h05;
    localparam logic [7:0] ADDR_EVT_LO = 8'h06;
    localparam logic [7:0] ADDR_EVT_HI = 8'h07;

    localparam int NUM_PORTS = 20;
    localparam int PORTS_PER_REG = 8;
    localparam int EVT_LO_W = 16;
    localparam int EVT_HI_W = 4;
    localparam int MODE_HI_W = 8;

    localparam logic [15:0] MASK_RESET = 16'hffff;
    localparam logic [15:0] MODE_RESET = 16'h0000;
    localparam logic [15:0] READ_ZERO = 16'h0000;

    // ==========================================================
    // edge modes
    // ==========================================================
    localparam logic [1:0] EDGE_NONE = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    // ==========================================================
    // timing
    // ==========================================================
    localparam int CLK_MHZ = 50;
    localparam int SWEEP_PULSE_NS = 100;
    localparam int SWEEP_PULSE_RAW = SWEEP_PULSE_NS * CLK_MHZ / 1000;
    localparam int SWEEP_PULSE_CYC = (SWEEP_PULSE_RAW < 1) ? 1
                                     : SWEEP_PULSE_RAW;
    localparam int PULSE_CNT_W = 4;

    // ==========================================================
    // interrupt bit layout, shared by the mask and the sources
    // ==========================================================
    typedef struct packed {
        logic supply_monitor;
        logic [2:0] remote2_temp;
        logic [2:0] remote1_temp;
        logic [2:0] die_temp;
        logic driver_overcurrent;
        logic input_event_missed;
        logic input_event_ready;
        logic conv_missed;
        logic conv_ready;
        logic conv_flag;
    } ime_irq_vec_t;

    // sources raised by neighbouring blocks, levels on ref_clk_in
    typedef struct packed {
        logic supply_monitor_irq;
        logic [2:0] remote2_temp_irq;
        logic [2:0] remote1_temp_irq;
        logic [2:0] die_temp_irq;
        logic driver_overcurrent_irq;
        logic conv_missed_irq;
        logic conv_ready_irq;
        logic conv_flag_irq;
    } ime_ext_src_t;

    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [15:0] wdata;
    } ime_reg_req_t;

    function automatic logic edge_hit(input logic [1:0] mode,
                                      input logic rise,
                                      input logic fall);
        logic hit;
        hit = 1'b0;
        unique case (mode)
            EDGE_NONE: hit = 1'b0;
            EDGE_RISE: hit = rise;
            EDGE_FALL: hit = fall;
            EDGE_BOTH: hit = rise | fall;
        endcase
        return hit;
    endfunction

endpackage

`default_nettype wire

// [hdl/ime_edge_detect.sv]
`default_nettype none

module ime_edge_detect (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic [19:0] pin_in,
    input wire logic [39:0] mode_in,
    output logic [19:0] hit_out
);

    typedef struct packed {
        logic [19:0] sync1;
        logic [19:0] sync2;
        logic [19:0] prev;
        logic [19:0] hit;
    } ime_edge_state_t;

    ime_edge_state_t st_q;
    ime_edge_state_t st_d;

    // ==========================================================
    // two-stage synchroniser, then edge compare on stage two only
    // ==========================================================
    always_comb
    begin
        st_d = st_q;
        st_d.sync1 = pin_in;
        st_d.sync2 = st_q.sync1;
        st_d.prev = st_q.sync2;
        for (int i = 0; i < ime_pkg::NUM_PORTS; i++)
        begin
            st_d.hit[i] = ime_pkg::edge_hit(mode_in[2*i +: 2],
                st_q.sync2[i] & ~st_q.prev[i],
                ~st_q.sync2[i] & st_q.prev[i]);
        end
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (sys_rst_in)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign hit_out = st_q.hit;

endmodule

`default_nettype wire

// [hdl/ime_pulse_timer.sv]
`default_nettype none

module ime_pulse_timer (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic start_in,
    output logic active_out
);

    typedef struct packed {
        logic [ime_pkg::PULSE_CNT_W-1:0] cnt;
        logic active;
    } ime_pulse_state_t;

    localparam logic [ime_pkg::PULSE_CNT_W-1:0] LOAD =
        ime_pkg::PULSE_CNT_W'(ime_pkg::SWEEP_PULSE_CYC);

    ime_pulse_state_t st_q;
    ime_pulse_state_t st_d;

    // ==========================================================
    // fixed-length pulse; a new start restarts the full length
    // ==========================================================
    always_comb
    begin
        st_d = st_q;
        if (start_in)
        begin
            st_d.cnt = LOAD;
            st_d.active = 1'b1;
        end
        else if (st_q.cnt != '0)
        begin
            st_d.cnt = st_q.cnt - 1'b1;
            st_d.active = (st_q.cnt != 1'b1);
        end
        else
        begin
            st_d.active = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (sys_rst_in)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign active_out = st_q.active;

endmodule

`default_nettype wire

// [hdl/ime_irq_ctrl.sv]
// Overview of operation
// - mask bit 0 set blocks converter flag from pulling interrupt low
// - continuous sweep pulses interrupt 100 ns per sweep end, unconditionally
// - mask bit 1 gates converter data-ready interrupt bit
// - mask bit 2 gates converter data-missed interrupt bit
// - mask bit 3 gates input-event-ready interrupt bit
// - ready mask set overrides edge modes for the interrupt pin
// - mask bit 4 gates input-event-missed interrupt bit
// - missed mask clears only while ready mask is, or becomes, clear
// - mask bit 5 gates driver overcurrent interrupt bit
// - mask bits 8:6 gate the three die temperature bits
// - mask bits 11:9 gate the three first remote temperature bits
// - mask bits 14:12 gate the three second remote temperature bits
// - mask bit 15 gates supply monitor interrupt bit
// - twenty 2-bit edge codes, eight per register (four in the last), port i at 2i+1:2i
// - code 00 never sets the port's event status bit
// - code 01 sets event status on rising edge
// - code 10 sets event status on falling edge
// - code 11 sets event status on either edge
// - event status records edges regardless of any mask
// - status clears after interrupt read, then low and high status reads
`default_nettype none

module ime_irq_ctrl (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [15:0] reg_wdata_in,
    output logic [15:0] reg_rdata_out,
    input wire ime_pkg::ime_ext_src_t src_in,
    input wire logic sweep_end_in,
    input wire logic continuous_sweep_in,
    input wire logic [19:0] input_pin_in,
    output logic [19:0] input_event_status_out,
    output logic int_n_out
);

    // ==========================================================
    // state
    // ==========================================================
    typedef struct packed {
        ime_pkg::ime_irq_vec_t mask;
        logic [15:0] mode_0_7;
        logic [15:0] mode_8_15;
        logic [15:0] mode_16_19;
        logic [19:0] input_event_status;
        logic input_event_missed;
        logic clr_armed;
        logic lo_seen;
        logic hi_seen;
        logic [15:0] rdata;
        logic int_n;
    } ime_ctrl_state_t;

    ime_ctrl_state_t st_q;
    ime_ctrl_state_t st_d;

    ime_pkg::ime_reg_req_t req;
    ime_pkg::ime_irq_vec_t irq_bits;
    ime_pkg::ime_irq_vec_t pending;
    ime_pkg::ime_irq_vec_t new_mask;

    logic [39:0] edge_modes;
    logic [19:0] edge_hits;
    logic sweep_pulse;
    logic sweep_start;
    logic clr_now;
    logic any_pending;
    logic [19:0] status_kept;

    // ==========================================================
    // request carrier
    // ==========================================================
    always_comb
    begin
        req.addr = reg_addr_in;
        req.wr = reg_wr_in;
        req.rd = reg_rd_in;
        req.wdata = reg_wdata_in;
    end

    // ==========================================================
    // edge mode packing
    // ==========================================================
    // port i sits at bits 2i+1:2i of the packed 40-bit edge_modes vector
    always_comb
    begin
        edge_modes = {st_q.mode_16_19[ime_pkg::MODE_HI_W-1:0],
                      st_q.mode_8_15,
                      st_q.mode_0_7};
    end

    ime_edge_detect u_edge (
        .ref_clk_in(ref_clk_in),
        .sys_rst_in(sys_rst_in),
        .pin_in(input_pin_in),
        .mode_in(edge_modes),
        .hit_out(edge_hits)
    );

    // ==========================================================
    // sweep-end pulse
    // ==========================================================
    // the pulse ignores both the mask and the flag's clear state
    always_comb
    begin
        sweep_start = sweep_end_in & continuous_sweep_in;
    end

    ime_pulse_timer u_sweep_pulse (
        .ref_clk_in(ref_clk_in),
        .sys_rst_in(sys_rst_in),
        .start_in(sweep_start),
        .active_out(sweep_pulse)
    );

    // ==========================================================
    // interrupt bit assembly
    // ==========================================================
    always_comb
    begin
        irq_bits.conv_flag = src_in.conv_flag_irq;
        irq_bits.conv_ready = src_in.conv_ready_irq;
        irq_bits.conv_missed = src_in.conv_missed_irq;
        irq_bits.input_event_ready = |st_q.input_event_status;
        irq_bits.input_event_missed = st_q.input_event_missed;
        irq_bits.driver_overcurrent = src_in.driver_overcurrent_irq;
        irq_bits.die_temp = src_in.die_temp_irq;
        irq_bits.remote1_temp = src_in.remote1_temp_irq;
        irq_bits.remote2_temp = src_in.remote2_temp_irq;
        irq_bits.supply_monitor = src_in.supply_monitor_irq;
    end

    // ==========================================================
    // masking: a mask bit of one blocks its source
    // ==========================================================
    always_comb
    begin
        pending.conv_flag =
            irq_bits.conv_flag & ~st_q.mask.conv_flag;
        pending.conv_ready =
            irq_bits.conv_ready & ~st_q.mask.conv_ready;
        pending.conv_missed =
            irq_bits.conv_missed & ~st_q.mask.conv_missed;
        // ready mask wins over any edge code that is configured
        pending.input_event_ready = irq_bits.input_event_ready
            & ~st_q.mask.input_event_ready;
        pending.input_event_missed = irq_bits.input_event_missed
            & ~st_q.mask.input_event_missed;
        pending.driver_overcurrent = irq_bits.driver_overcurrent
            & ~st_q.mask.driver_overcurrent;
        pending.die_temp =
            irq_bits.die_temp & ~st_q.mask.die_temp;
        pending.remote1_temp =
            irq_bits.remote1_temp & ~st_q.mask.remote1_temp;
        pending.remote2_temp =
            irq_bits.remote2_temp & ~st_q.mask.remote2_temp;
        pending.supply_monitor = irq_bits.supply_monitor
            & ~st_q.mask.supply_monitor;
        any_pending = |pending;
    end

    // ==========================================================
    // mask write filter
    // ==========================================================
    // missed mask may only drop once ready mask is, or goes, clear
    always_comb
    begin
        new_mask = ime_pkg::ime_irq_vec_t'(req.wdata);
        if (!new_mask.input_event_missed
            && new_mask.input_event_ready
            && st_q.mask.input_event_ready)
        begin
            new_mask.input_event_missed =
                st_q.mask.input_event_missed;
        end
    end

    // ==========================================================
    // status clear sequence
    // ==========================================================
    // armed by the interrupt read, fires once both halves are read
    always_comb
    begin
        clr_now = 1'b0;
        if (st_q.clr_armed && req.rd)
        begin
            if (req.addr == ime_pkg::ADDR_EVT_LO)
                clr_now = st_q.hi_seen;
            else if (req.addr == ime_pkg::ADDR_EVT_HI)
                clr_now = st_q.lo_seen;
        end
        status_kept = clr_now ? '0 : st_q.input_event_status;
    end

    // ==========================================================
    // next state
    // ==========================================================
    always_comb
    begin
        st_d = st_q;

        // edges land in status whatever the mask says; set beats clear
        st_d.input_event_status = status_kept | edge_hits;

        // an edge on a port whose status bit is already set, even in the clearing cycle, flags a missed event
        if (|(edge_hits & st_q.input_event_status & ~status_kept))
            st_d.input_event_missed = 1'b1;
        else if (|(edge_hits & status_kept))
            st_d.input_event_missed = 1'b1;
        else if (clr_now)
            st_d.input_event_missed = 1'b0;

        // clear-sequence tracking
        if (req.rd)
        begin
            if (req.addr == ime_pkg::ADDR_IRQ_STATUS)
            begin
                st_d.clr_armed = 1'b1;
                st_d.lo_seen = 1'b0;
                st_d.hi_seen = 1'b0;
            end
            else if (clr_now)
            begin
                st_d.clr_armed = 1'b0;
                st_d.lo_seen = 1'b0;
                st_d.hi_seen = 1'b0;
            end
            else if (st_q.clr_armed
                     && req.addr == ime_pkg::ADDR_EVT_LO)
            begin
                st_d.lo_seen = 1'b1;
            end
            else if (st_q.clr_armed
                     && req.addr == ime_pkg::ADDR_EVT_HI)
            begin
                st_d.hi_seen = 1'b1;
            end
        end

        // register writes
        if (req.wr)
        begin
            unique case (req.addr)
                ime_pkg::ADDR_MASK:
                    st_d.mask = new_mask;
                ime_pkg::ADDR_MODE_0_7:
                    st_d.mode_0_7 = req.wdata;
                ime_pkg::ADDR_MODE_8_15:
                    st_d.mode_8_15 = req.wdata;
                ime_pkg::ADDR_MODE_16_19:
                    st_d.mode_16_19 = {8'h00,
                        req.wdata[ime_pkg::MODE_HI_W-1:0]};
                default:
                    st_d.mode_0_7 = st_q.mode_0_7;
            endcase
        end

        // register reads, data valid on the next edge
        if (req.rd)
        begin
            unique case (req.addr)
                ime_pkg::ADDR_IRQ_STATUS:
                    st_d.rdata = irq_bits;
                ime_pkg::ADDR_MASK:
                    st_d.rdata = st_q.mask;
                ime_pkg::ADDR_MODE_0_7:
                    st_d.rdata = st_q.mode_0_7;
                ime_pkg::ADDR_MODE_8_15:
                    st_d.rdata = st_q.mode_8_15;
                ime_pkg::ADDR_MODE_16_19:
                    st_d.rdata = st_q.mode_16_19;
                ime_pkg::ADDR_EVT_LO:
                    st_d.rdata =
                        st_q.input_event_status[ime_pkg::EVT_LO_W-1:0];
                ime_pkg::ADDR_EVT_HI:
                    st_d.rdata = {12'h000,
                        st_q.input_event_status[ime_pkg::NUM_PORTS-1:
                                                ime_pkg::EVT_LO_W]};
                default:
                    st_d.rdata = ime_pkg::READ_ZERO;
            endcase
        end

        // pin: low for unmasked bits or during the sweep pulse
        st_d.int_n = ~(any_pending | sweep_pulse);
    end

    // ==========================================================
    // registers
    // ==========================================================
    always_ff @(posedge ref_clk_in)
    begin
        if (sys_rst_in)
        begin
            st_q <= '0;
            st_q.mask <= ime_pkg::MASK_RESET;
            st_q.mode_0_7 <= ime_pkg::MODE_RESET;
            st_q.mode_8_15 <= ime_pkg::MODE_RESET;
            st_q.mode_16_19 <= ime_pkg::MODE_RESET;
            st_q.int_n <= 1'b1;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // ==========================================================
    // outputs
    // ==========================================================
    assign reg_rdata_out = st_q.rdata;
    assign input_event_status_out = st_q.input_event_status;
    assign int_n_out = st_q.int_n;

endmodule

`default_nettype wire

// [verification/ime_irq_ctrl_assertions.sv]
`default_nettype none

module ime_irq_ctrl_checker (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic [15:0] reg_rdata_out,
    input wire ime_pkg::ime_ext_src_t src_in,
    input wire logic sweep_end_in,
    input wire logic continuous_sweep_in,
    input wire logic [19:0] input_pin_in,
    input wire logic [19:0] input_event_status_out,
    input wire logic int_n_out
);
    timeunit 1ns;
    timeprecision 100ps;

    // ==========================================================
    // shadow mask and cycles since the last sweep end
    // ==========================================================
    logic [15:0] mask_q;
    logic [15:0] src_vec;
    logic [2:0] quiet_q;
    assign src_vec = {src_in[13:3], 2'h0, src_in[2:0]};

    always_ff @(posedge ref_clk_in)
    begin
        if (sys_rst_in)
        begin
            mask_q <= ime_pkg::MASK_RESET;
            quiet_q <= 3'h7;
        end
        else
        begin
            if (reg_wr_in && reg_addr_in == ime_pkg::ADDR_MASK)
            begin
                mask_q <= reg_wdata_in;
                if (mask_q[3] && reg_wdata_in[3] && !reg_wdata_in[4])
                    mask_q[4] <= mask_q[4];
            end
            if (sweep_end_in && continuous_sweep_in)
                quiet_q <= 3'h0;
            else if (quiet_q != 3'h7)
                quiet_q <= quiet_q + 3'h1;
        end
    end

    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (sys_rst_in);

    // ==========================================================
    // assertions
    // ==========================================================
    reset_state_a: assert property (disable iff (1'b0) sys_rst_in |=>
        int_n_out && reg_rdata_out == 16'h0 && input_event_status_out == 20'h0)
        else $error("outputs not idle after reset");
    src_unmask_a: assert property (|(src_vec & ~mask_q) |=> !int_n_out)
        else $error("unmasked source did not pull interrupt low");
    all_masked_a: assert property (quiet_q == 3'h7
        && $past(mask_q) == 16'hffff |-> int_n_out)
        else $error("interrupt low while everything masked");
    ready_int_a: assert property (!mask_q[3] && |input_event_status_out
        |=> !int_n_out) else $error("event status did not raise interrupt");
    sweep_pulse_a: assert property (sweep_end_in && continuous_sweep_in
        |-> ##2 (!int_n_out) [*5]) else $error("sweep pulse too short");
    mask_read_a: assert property (reg_rd_in && !reg_wr_in
        && reg_addr_in == ime_pkg::ADDR_MASK |=> reg_rdata_out == $past(mask_q))
        else $error("mask read back wrong");
    unmapped_rd_a: assert property (reg_rd_in
        && (reg_addr_in == 8'h00 || reg_addr_in > 8'h07) |=> reg_rdata_out == 16'h0)
        else $error("unmapped read not zero");
    mode_hi_a: assert property (reg_rd_in
        && reg_addr_in == ime_pkg::ADDR_MODE_16_19 |=> reg_rdata_out[15:8] == 8'h0)
        else $error("upper mode byte not zero");
    status_keep_a: assert property (!$past(reg_rd_in) && !$past(sys_rst_in)
        |-> ($past(input_event_status_out) & ~input_event_status_out) == 20'h0)
        else $error("event status dropped without a read");
endmodule

bind ime_irq_ctrl ime_irq_ctrl_checker i_ime_irq_ctrl_checker (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .reg_addr_in(reg_addr_in),
    .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in),
    .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out),
    .src_in(src_in),
    .sweep_end_in(sweep_end_in),
    .continuous_sweep_in(continuous_sweep_in),
    .input_pin_in(input_pin_in),
    .input_event_status_out(input_event_status_out),
    .int_n_out(int_n_out)
);

`default_nettype wire

// [verification/ime_host_model.sv]
`default_nettype none

module ime_host_model (
    input wire logic ref_clk_in,
    input wire logic [15:0] reg_rdata_in,
    output logic [7:0] reg_addr_out,
    output logic reg_wr_out,
    output logic reg_rd_out,
    output logic [15:0] reg_wdata_out
);
    timeunit 1ns;
    timeprecision 100ps;

    initial
    begin
        reg_addr_out = 8'hff;
        reg_wr_out = 1'b0;
        reg_rd_out = 1'b0;
        reg_wdata_out = 16'h0;
    end

    // every transfer starts one edge late so strobes never re-rise at once
    task automatic step();
        @(posedge ref_clk_in);
        #1;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        step();
        reg_addr_out = a;
        reg_wdata_out = d;
        reg_wr_out = 1'b1;
        step();
        reg_wr_out = 1'b0;
        // released lines show junk, not the last word
        reg_addr_out = ~a;
        reg_wdata_out = ~d;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
        step();
        reg_addr_out = a;
        reg_rd_out = 1'b1;
        step();
        reg_rd_out = 1'b0;
        reg_addr_out = ~a;
        d = reg_rdata_in;
    endtask

    task automatic clear_events();
        logic [15:0] d;
        rd_reg(ime_pkg::ADDR_IRQ_STATUS, d);
        rd_reg(ime_pkg::ADDR_EVT_LO, d);
        rd_reg(ime_pkg::ADDR_EVT_HI, d);
    endtask
endmodule

`default_nettype wire

// [verification/tb_ime_irq_ctrl.sv]
`default_nettype none

module tb_ime_irq_ctrl;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk = 1'b0;
    logic rst = 1'b1;
    ime_pkg::ime_ext_src_t src = '0;
    logic sweep_end = 1'b0;
    logic cont = 1'b0;
    logic [19:0] pins = 20'h0;
    logic [15:0] rdata;
    logic [19:0] status;
    logic int_n;
    logic [7:0] addr;
    logic wr_en;
    logic rd;
    logic [15:0] wdata;
    int failures = 0;
    int n_checks = 0;
    int cycles = 0;

    always #10 clk = ~clk;

    ime_irq_ctrl i_ime_irq_ctrl (
        .ref_clk_in(clk),
        .sys_rst_in(rst),
        .reg_addr_in(addr),
        .reg_wr_in(wr_en),
        .reg_rd_in(rd),
        .reg_wdata_in(wdata),
        .reg_rdata_out(rdata),
        .src_in(src),
        .sweep_end_in(sweep_end),
        .continuous_sweep_in(cont),
        .input_pin_in(pins),
        .input_event_status_out(status),
        .int_n_out(int_n)
    );

    ime_host_model i_ime_host_model (
        .ref_clk_in(clk),
        .reg_rdata_in(rdata),
        .reg_addr_out(addr),
        .reg_wr_out(wr_en),
        .reg_rd_out(rd),
        .reg_wdata_out(wdata)
    );

    // ==========================================================
    // helpers
    // ==========================================================
    task automatic results();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            failures++;
            results();
        end
    end

    task automatic check(input logic [19:0] seen, input logic [19:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        i_ime_host_model.wr_reg(a, d);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
        logic [15:0] d;
        i_ime_host_model.rd_reg(a, d);
        check(20'(d), 20'(e));
    endtask

    // ==========================================================
    // scenarios
    // ==========================================================
    task automatic t_reset();
        check(20'(int_n), 20'h1);
        check(status, 20'h0);
        rd_chk(ime_pkg::ADDR_MASK, ime_pkg::MASK_RESET);
        rd_chk(ime_pkg::ADDR_MODE_0_7, ime_pkg::MODE_RESET);
        rd_chk(ime_pkg::ADDR_MODE_16_19, ime_pkg::MODE_RESET);
        $display("test reset done");
    endtask

    task automatic t_mask_gate();
        int m;
        for (int k = 0; k < 14; k++)
        begin
            m = (k < 3) ? k : k + 2;
            wr(ime_pkg::ADDR_MASK, ~(16'h1 << m));
            src = ime_pkg::ime_ext_src_t'(14'h1 << k);
            step(2);
            check(20'(int_n), 20'h0);
            wr(ime_pkg::ADDR_MASK, 16'hffff);
            step(2);
            check(20'(int_n), 20'h1);
            src = '0;
        end
        $display("test mask gating done");
    endtask

    task automatic t_regs();
        wr(ime_pkg::ADDR_MASK, 16'hffef);
        rd_chk(ime_pkg::ADDR_MASK, 16'hffff);
        wr(ime_pkg::ADDR_MASK, 16'hffe7);
        rd_chk(ime_pkg::ADDR_MASK, 16'hffe7);
        wr(ime_pkg::ADDR_MASK, 16'hffff);
        wr(ime_pkg::ADDR_MODE_16_19, 16'hffff);
        rd_chk(ime_pkg::ADDR_MODE_16_19, 16'h00ff);
        wr(ime_pkg::ADDR_MODE_8_15, 16'h5a3c);
        rd_chk(ime_pkg::ADDR_MODE_8_15, 16'h5a3c);
        wr(8'h20, 16'h0000);
        rd_chk(8'h20, 16'h0000);
        rd_chk(ime_pkg::ADDR_MASK, 16'hffff);
        $display("test registers done");
    endtask

    task automatic t_edges();
        wr(ime_pkg::ADDR_MODE_0_7, 16'h00e4);
        wr(ime_pkg::ADDR_MODE_8_15, 16'h0001);
        wr(ime_pkg::ADDR_MODE_16_19, 16'h00c0);
        pins = 20'h8010f;
        step(6);
        check(status, 20'h8010a);
        check(20'(int_n), 20'h1);
        rd_chk(ime_pkg::ADDR_EVT_LO, 16'h010a);
        rd_chk(ime_pkg::ADDR_EVT_HI, 16'h0008);
        check(status, 20'h8010a);
        i_ime_host_model.clear_events();
        check(status, 20'h0);
        pins = 20'h0;
        step(6);
        check(status, 20'h8000c);
        wr(ime_pkg::ADDR_MASK, 16'hfff7);
        step(2);
        check(20'(int_n), 20'h0);
        wr(ime_pkg::ADDR_MASK, 16'hffff);
        step(2);
        check(20'(int_n), 20'h1);
        pins = 20'h00008;
        step(6);
        rd_chk(ime_pkg::ADDR_IRQ_STATUS, 16'h0018);
        wr(ime_pkg::ADDR_MASK, 16'hffe7);
        step(2);
        check(20'(int_n), 20'h0);
        wr(ime_pkg::ADDR_MASK, 16'hffff);
        i_ime_host_model.clear_events();
        check(status, 20'h0);
        rd_chk(ime_pkg::ADDR_IRQ_STATUS, 16'h0000);
        $display("test edges done");
    endtask

    task automatic count_lows(output int n);
        n = 0;
        repeat (10)
        begin
            if (int_n === 1'b0)
                n++;
            step(1);
        end
    endtask

    task automatic t_sweep();
        int n;
        src.conv_flag_irq = 1'b1;
        cont = 1'b1;
        sweep_end = 1'b1;
        step(1);
        sweep_end = 1'b0;
        count_lows(n);
        check(20'(n), 20'h5);
        cont = 1'b0;
        sweep_end = 1'b1;
        step(1);
        sweep_end = 1'b0;
        count_lows(n);
        check(20'(n), 20'h0);
        src = '0;
        $display("test sweep done");
    endtask

    initial
    begin
        step(2);
        rst = 1'b0;
        t_reset();
        t_mask_gate();
        t_regs();
        t_edges();
        t_sweep();
        results();
    end
endmodule

`default_nettype wire
